// ==== logic/motion_cmd_pkg.sv ====
// Package: command codes, word counts, ranges, timing and carrier structs
package motion_cmd_pkg;

  // ****************
  // Command codes
  // ****************
  localparam logic [7:0] CMD_SEGMENT_QUEUE_CLEAR = 8'hfe;
  localparam logic [7:0] CMD_ABSOLUTE_TIMED_MOVE = 8'hb0;
  localparam logic [7:0] CMD_ABSOLUTE_VELOCITY_MOVE = 8'h86;
  localparam logic [7:0] CMD_RELATIVE_TIMED_MOVE = 8'hb1;
  localparam logic [7:0] CMD_RELATIVE_VELOCITY_MOVE = 8'h87;
  localparam logic [7:0] CMD_SEGMENT_WRITE = 8'hff;

  // ****************
  // Parameter layout and ranges
  // ****************
  localparam int MOVE_PARAM_WORDS = 5;
  localparam int SEGMENT_WORDS = 4;
  localparam int SEGMENT_DEPTH = 4;
  localparam logic [31:0] RAMP_TIME_MAX = 32'h0000fffe;
  localparam logic [31:0] TOTAL_TIME_MIN = 32'h00000002;
  localparam logic [31:0] ACCEL_MIN = 32'h00000001;
  localparam logic [31:0] ACCEL_MAX = 32'h3fffffff;
  localparam logic [31:0] VELOCITY_MAX = 32'h7fffffff;

  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_US = 120;
  localparam int TICK_CYCLES = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  // ****************
  // Answer codes
  // ****************
  localparam logic [1:0] ANS_ACK = 2'h0;
  localparam logic [1:0] ANS_NAK_FULL = 2'h1;
  localparam logic [1:0] ANS_NAK_RANGE = 2'h2;
  localparam logic [1:0] ANS_NAK_UNKNOWN = 2'h3;

  typedef struct packed {
    logic [31:0] seg_time;
    logic [31:0] position;
    logic [31:0] accel;
    logic [31:0] speed;
  } segment_s;

  typedef struct packed {
    logic relative;
    logic timed;
    logic [31:0] position;
    logic [31:0] param_a;
    logic [31:0] param_b;
    logic [15:0] stop_enable;
    logic [15:0] stop_state;
  } move_s;

endpackage

// ==== logic/segment_queue.sv ====
// Four-deep segment FIFO with clear
`timescale 1ns/1ns
module segment_queue #(
  parameter int DEPTH = 4
) (
  input wire logic sys_clk_in, // Clock
  input wire logic reset_n_in, // Sync reset, active low
  input wire logic clear_in, // Discard all entries
  input wire logic push_in, // Store segment
  input wire motion_cmd_pkg::segment_s push_data_in, // Segment to store
  input wire logic pop_in, // Take oldest segment
  output motion_cmd_pkg::segment_s pop_data_out, // Oldest segment
  output logic full_out, // No room
  output logic empty_out // Nothing held
);
  localparam int AW = $clog2(DEPTH);
  motion_cmd_pkg::segment_s mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_push = push_in && !full_out;
  wire do_pop = pop_in && !empty_out;

  assign full_out = (cnt_q == (AW+1)'(DEPTH));
  assign empty_out = (cnt_q == '0);
  assign pop_data_out = mem_q[rd_q];

  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || clear_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  chk_never_overfill: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cnt_q <= (AW+1)'(DEPTH)) else $error("Queue count above depth");
  chk_clear_empties: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clear_in |=> empty_out) else $error("Queue not empty after clear");
endmodule

// ==== logic/motion_command_queue_decoder.sv ====
// Command decoder for queue-clear, segment write and four move commands
`timescale 1ns/1ns
// ****************
// ****************
module motion_command_queue_decoder #(
  parameter int TICK_COUNT = motion_cmd_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_in, // Clock, 250 MHz
  input wire logic reset_n_in, // Sync reset, active low
  input wire logic cmd_valid_in, // Command or parameter word valid
  output logic cmd_ready_out, // Word accepted
  input wire logic cmd_first_in, // Word is a command code
  input wire logic [31:0] cmd_word_in, // Code in low byte, or parameter
  output logic ans_valid_out, // Answer pulse
  output logic [1:0] ans_code_out, // ACK or NAK kind
  input wire logic seg_pop_in, // Interpolator takes a segment
  output motion_cmd_pkg::segment_s seg_data_out, // Oldest segment
  output logic seg_empty_out, // Queue empty
  output logic move_start_out, // One-cycle move start
  output motion_cmd_pkg::move_s move_out, // Move parameters, resolved absolute
  input wire logic [31:0] target_pos_in, // Current target position
  output logic tick_out // Control tick pulse
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PARAM = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_SKIP = 4'b1000
  } state_e;

  state_e state_d, state_q;
  logic [7:0] code_q;
  logic [2:0] idx_q;
  logic [31:0] words_q [motion_cmd_pkg::MOVE_PARAM_WORDS];
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic ans_valid_q;
  logic [1:0] ans_code_q;
  logic move_start_q;
  motion_cmd_pkg::move_s move_q;
  logic seg_full;

  // ****************
  // Control tick
  // ****************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in || tick_cnt_q == 16'(TICK_COUNT - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    tick_q <= reset_n_in && (tick_cnt_q == 16'(TICK_COUNT - 1));
  end
  assign tick_out = tick_q;

  // ****************
  // Decode
  // ****************
  wire is_clear = cmd_word_in[7:0] == motion_cmd_pkg::CMD_SEGMENT_QUEUE_CLEAR;
  wire is_seg = cmd_word_in[7:0] == motion_cmd_pkg::CMD_SEGMENT_WRITE;
  wire is_move = cmd_word_in[7:0] == motion_cmd_pkg::CMD_ABSOLUTE_TIMED_MOVE
    || cmd_word_in[7:0] == motion_cmd_pkg::CMD_ABSOLUTE_VELOCITY_MOVE
    || cmd_word_in[7:0] == motion_cmd_pkg::CMD_RELATIVE_TIMED_MOVE
    || cmd_word_in[7:0] == motion_cmd_pkg::CMD_RELATIVE_VELOCITY_MOVE;
  wire [2:0] need = (code_q == motion_cmd_pkg::CMD_SEGMENT_WRITE) ?
    3'(motion_cmd_pkg::SEGMENT_WORDS) : 3'(motion_cmd_pkg::MOVE_PARAM_WORDS);
  wire take = cmd_valid_in && cmd_ready_out;
  wire start_cmd = take && cmd_first_in;
  wire last_param = take && !cmd_first_in && state_q == ST_PARAM && idx_q == need - 3'h1;
  wire timed = code_q[5]; // 0xb0/0xb1 vs 0x86/0x87
  wire relative = code_q[0];

  // Range checks on the collected move words
  wire ramp_ok = words_q[1] <= motion_cmd_pkg::RAMP_TIME_MAX;
  wire total_ok = words_q[2] >= motion_cmd_pkg::TOTAL_TIME_MIN
    && words_q[2] <= motion_cmd_pkg::VELOCITY_MAX;
  wire accel_ok = words_q[1] >= motion_cmd_pkg::ACCEL_MIN
    && words_q[1] <= motion_cmd_pkg::ACCEL_MAX;
  wire vel_ok = words_q[2] <= motion_cmd_pkg::VELOCITY_MAX;
  wire params_ok = timed ? (ramp_ok && total_ok) : (accel_ok && vel_ok);
  wire [31:0] resolved_pos = relative ? words_q[0] + target_pos_in : words_q[0];

  wire motion_cmd_pkg::segment_s seg_in = {words_q[0], words_q[1], words_q[2], words_q[3]};
  wire seg_push = state_q == ST_EXEC && code_q == motion_cmd_pkg::CMD_SEGMENT_WRITE
    && !seg_full;
  wire seg_clear = start_cmd && is_clear;

  assign cmd_ready_out = (state_q != ST_EXEC);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_cmd && (is_seg || is_move)) state_d = ST_PARAM;
      end
      ST_PARAM: begin
        if (start_cmd) state_d = (is_seg || is_move) ? ST_PARAM : ST_IDLE;
        else if (last_param) state_d = ST_EXEC;
      end
      ST_EXEC: state_d = ST_IDLE;
      ST_SKIP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      code_q <= 8'h00;
      idx_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (start_cmd) begin
        code_q <= cmd_word_in[7:0];
        idx_q <= 3'h0;
      end else if (take && state_q == ST_PARAM) begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (take && !cmd_first_in && state_q == ST_PARAM) begin
      words_q[idx_q] <= cmd_word_in;
    end
  end

  // ****************
  // Answers and move start
  // ****************
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ans_valid_q <= 1'b0;
      ans_code_q <= motion_cmd_pkg::ANS_ACK;
      move_start_q <= 1'b0;
      move_q <= '0;
    end else begin
      ans_valid_q <= 1'b0;
      move_start_q <= 1'b0;
      if (seg_clear) begin
        ans_valid_q <= 1'b1;
        ans_code_q <= motion_cmd_pkg::ANS_ACK;
      end else if (start_cmd && !is_seg && !is_move) begin
        ans_valid_q <= 1'b1;
        ans_code_q <= motion_cmd_pkg::ANS_NAK_UNKNOWN;
      end else if (state_q == ST_EXEC) begin
        ans_valid_q <= 1'b1;
        if (code_q == motion_cmd_pkg::CMD_SEGMENT_WRITE) begin
          // Dropped segment relies on host resend
          ans_code_q <= seg_full ? motion_cmd_pkg::ANS_NAK_FULL
            : motion_cmd_pkg::ANS_ACK;
        end else if (params_ok) begin
          ans_code_q <= motion_cmd_pkg::ANS_ACK;
          move_start_q <= 1'b1;
          move_q <= '{relative: relative, timed: timed, position: resolved_pos,
            param_a: words_q[1], param_b: words_q[2],
            stop_enable: words_q[3][15:0], stop_state: words_q[4][15:0]};
        end else begin
          ans_code_q <= motion_cmd_pkg::ANS_NAK_RANGE;
        end
      end
    end
  end
  assign ans_valid_out = ans_valid_q;
  assign ans_code_out = ans_code_q;
  assign move_start_out = move_start_q;
  assign move_out = move_q;

  segment_queue #(.DEPTH(motion_cmd_pkg::SEGMENT_DEPTH)) u_queue (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(seg_clear),
    .push_in(seg_push),
    .push_data_in(seg_in),
    .pop_in(seg_pop_in),
    .pop_data_out(seg_data_out),
    .full_out(seg_full),
    .empty_out(seg_empty_out)
  );

  // ****************
  // Checks
  // ****************
  chk_full_naks: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (state_q == ST_EXEC && code_q == motion_cmd_pkg::CMD_SEGMENT_WRITE && seg_full)
    |=> ans_valid_out && ans_code_out == motion_cmd_pkg::ANS_NAK_FULL)
    else $error("Full queue not answered NAK-full");
  chk_seg_ack: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    seg_push |=> ans_valid_out && ans_code_out == motion_cmd_pkg::ANS_ACK)
    else $error("Stored segment not acknowledged");
  chk_clear_ack: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    seg_clear |=> ans_valid_out && ans_code_out == motion_cmd_pkg::ANS_ACK
    && seg_empty_out) else $error("Queue clear not acked or not empty");
  chk_ramp_range: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    move_start_out && move_out.timed |-> move_out.param_a <= 32'h0000fffe
    && move_out.param_b >= 32'h00000002) else $error("Timed move out of range");
  chk_accel_range: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    move_start_out && !move_out.timed |-> move_out.param_a != 32'h00000000
    && move_out.param_a <= 32'h3fffffff) else $error("Accel out of range");
  chk_rel_target: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (state_q == ST_EXEC && relative && params_ok
    && code_q != motion_cmd_pkg::CMD_SEGMENT_WRITE)
    |=> move_out.position == words_q[0] + $past(target_pos_in))
    else $error("Relative move not based on target");
  chk_vel_range: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    move_start_out && !move_out.timed |-> !move_out.param_b[31])
    else $error("Velocity out of range");
  // Back-to-back answers are legal, so each pulse is tied to its own cause instead
  chk_single_ans: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ans_valid_out |-> $past(seg_clear || (start_cmd && !is_seg && !is_move)
    || state_q == ST_EXEC)) else $error("Answer without a cause");
  chk_tick_period: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    tick_out |=> !tick_out [*8]) else $error("Tick too frequent");
endmodule

// ==== bench/host_model.sv ====
// Host controller model that sends command and parameter words
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk_in, // Clock
  input wire logic cmd_ready_in, // Word accepted
  output logic cmd_valid_out, // Word valid
  output logic cmd_first_out, // Word is a command code
  output logic [31:0] cmd_word_out // Code or parameter
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_first_out = 1'b0;
    cmd_word_out = 32'h0;
  end

  // Word held until the edge that takes it; ready is read before that edge
  task automatic put(input logic first, input logic [31:0] w, output bit ok);
    bit r;
    int n;
    cmd_valid_out <= 1'b1;
    cmd_first_out <= first;
    cmd_word_out <= w;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(negedge sys_clk_in);
      r = cmd_ready_in;
      @(posedge sys_clk_in);
      ok = r;
    end
  endtask

  // Gap between words models a slow host; released word is inverted, not held
  task automatic send(input logic [7:0] code, input logic [31:0] p [5], input int n,
                      input int gap, output bit ok);
    int k;
    put(1'b1, {24'h0, code}, ok);
    for (k = 0; k < n && ok; k++) begin
      if (gap > 0) begin
        cmd_valid_out <= 1'b0;
        cmd_word_out <= ~cmd_word_out;
        repeat (gap) @(posedge sys_clk_in);
      end
      put(1'b0, p[k], ok);
    end
    cmd_valid_out <= 1'b0;
    cmd_word_out <= ~cmd_word_out;
  endtask
endmodule

// ==== bench/motion_command_queue_decoder_tb.sv ====
// Self-checking bench for the motion command decoder
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module motion_command_queue_decoder_tb;
  localparam int TICKS = 16;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic seg_pop = 1'b0;
  logic [31:0] target_pos = 32'h0;
  logic cmd_valid, cmd_ready, cmd_first, ans_valid, seg_empty, move_start, tick;
  logic [31:0] cmd_word;
  logic [1:0] ans_code;
  motion_cmd_pkg::segment_s seg_data;
  motion_cmd_pkg::move_s move;
  logic [1:0] ans_q[$];
  motion_cmd_pkg::move_s mv_q[$];
  logic [127:0] seg_model[$];
  int errors = 0;
  int comparisons = 0;
  int tick_gap = 0;
  int tick_seen = 0;
  logic [7:0] codes [4] = '{8'hb0, 8'h86, 8'hb1, 8'h87};
  logic [7:0] bad_code [5] = '{8'hb0, 8'hb1, 8'h86, 8'h87, 8'h87};
  int bad_idx [5] = '{1, 2, 1, 1, 2};
  logic [31:0] bad_val [5] = '{32'h0000ffff, 32'h1, 32'h0, 32'h40000000, 32'h80000000};

  always #2 sys_clk_in = ~sys_clk_in;

  motion_command_queue_decoder #(.TICK_COUNT(TICKS)) i_motion_command_queue_decoder (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_first_in(cmd_first), .cmd_word_in(cmd_word),
    .ans_valid_out(ans_valid), .ans_code_out(ans_code), .seg_pop_in(seg_pop),
    .seg_data_out(seg_data), .seg_empty_out(seg_empty), .move_start_out(move_start),
    .move_out(move), .target_pos_in(target_pos), .tick_out(tick));

  host_model i_host_model (.sys_clk_in(sys_clk_in), .cmd_ready_in(cmd_ready),
    .cmd_valid_out(cmd_valid), .cmd_first_out(cmd_first), .cmd_word_out(cmd_word));

  // Outputs captured mid-cycle, where registered values have settled
  always @(negedge sys_clk_in) begin
    if (ans_valid === 1'b1) ans_q.push_back(ans_code);
    if (move_start === 1'b1) mv_q.push_back(move);
    tick_gap++;
    if (tick === 1'b1) begin
      if (tick_seen > 0) `CHK(tick_gap, TICKS)
      tick_seen++;
      tick_gap = 0;
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic issue(input logic [7:0] code, input logic [31:0] p [5], input int n,
                       input int gap, input logic [1:0] exp);
    bit ok;
    int k;
    logic [1:0] got_ans;
    i_host_model.send(code, p, n, gap, ok);
    for (k = 0; k < 20 && ans_q.size() == 0; k++) @(posedge sys_clk_in);
    if (!ok || ans_q.size() == 0) begin
      errors++;
      tally_and_finish();
    end else begin
      // Popped once here: the macro evaluates its arguments twice on a mismatch
      got_ans = ans_q.pop_front();
      `CHK(got_ans, exp)
    end
  endtask

  task automatic pop_check();
    logic [127:0] want_seg;
    @(negedge sys_clk_in);
    want_seg = seg_model.pop_front();
    `CHK(seg_data, want_seg)
    @(posedge sys_clk_in);
    seg_pop <= 1'b1;
    @(posedge sys_clk_in);
    seg_pop <= 1'b0;
  endtask

  initial begin
    logic [31:0] p [5];
    logic [7:0] code;
    motion_cmd_pkg::move_s m;
    motion_cmd_pkg::move_s got;
    int i;
    int k;
    void'($urandom(25));
    repeat (8) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    `CHK(seg_empty, 1'b1)
    // Fifth write finds the queue full; same data resent after one pop
    for (i = 0; i < 5; i++) begin
      for (k = 0; k < 4; k++) p[k] = $urandom;
      issue(motion_cmd_pkg::CMD_SEGMENT_WRITE, p, 4, i % 2,
            (i < 4) ? motion_cmd_pkg::ANS_ACK : motion_cmd_pkg::ANS_NAK_FULL);
      if (i < 4) seg_model.push_back({p[0], p[1], p[2], p[3]});
    end
    pop_check();
    issue(motion_cmd_pkg::CMD_SEGMENT_WRITE, p, 4, 0, motion_cmd_pkg::ANS_ACK);
    seg_model.push_back({p[0], p[1], p[2], p[3]});
    repeat (4) pop_check();
    // Last pop lands on the edge just passed; look once the count has settled
    @(negedge sys_clk_in);
    `CHK(seg_empty, 1'b1)
    for (i = 0; i < 2; i++) issue(motion_cmd_pkg::CMD_SEGMENT_WRITE, p, 4, 0, 2'h0);
    issue(motion_cmd_pkg::CMD_SEGMENT_QUEUE_CLEAR, p, 0, 0, motion_cmd_pkg::ANS_ACK);
    `CHK(seg_empty, 1'b1)
    issue(8'h55, p, 0, 0, motion_cmd_pkg::ANS_NAK_UNKNOWN);
    // Moves: bit 0 of the code marks relative, bit 4 marks timed
    for (i = 0; i < 8; i++) begin
      code = codes[i % 4];
      target_pos <= $urandom;
      p[0] = $urandom;
      p[3] = $urandom & 32'h0000ffff;
      p[4] = $urandom & 32'h0000ffff;
      if (code[4]) begin
        p[1] = (i < 4) ? motion_cmd_pkg::RAMP_TIME_MAX : $urandom % 65535;
        p[2] = (i < 4) ? motion_cmd_pkg::TOTAL_TIME_MIN : 2 + $urandom % 9000;
      end else begin
        p[1] = (i < 4) ? motion_cmd_pkg::ACCEL_MAX : 1 + $urandom % motion_cmd_pkg::ACCEL_MAX;
        p[2] = (i < 4) ? motion_cmd_pkg::VELOCITY_MAX : $urandom % (2 * p[1]);
      end
      @(posedge sys_clk_in);
      m = {code[0], code[4], code[0] ? p[0] + target_pos : p[0], p[1], p[2], p[3][15:0],
           p[4][15:0]};
      issue(code, p, 5, i % 3, motion_cmd_pkg::ANS_ACK);
      got = (mv_q.size() == 1) ? mv_q.pop_front() : 'x;
      `CHK(got, m)
    end
    // Each out-of-range field refused with no move started
    for (i = 0; i < 5; i++) begin
      p[1] = 32'h10;
      p[2] = 32'h10;
      p[bad_idx[i]] = bad_val[i];
      issue(bad_code[i], p, 5, 0, motion_cmd_pkg::ANS_NAK_RANGE);
      `CHK(mv_q.size(), 0)
    end
    repeat (4 * TICKS) @(posedge sys_clk_in);
    `CHK(tick_seen > 4, 1'b1)
    tally_and_finish();
  end
endmodule
